// [include/fci_pkg.sv]
// shared constants and types for the flash command host
package fci_pkg;

  // timing
  localparam int CLK_NS        = 100;
  localparam int T_RST_LOW_NS  = 500;
  localparam int T_RST_DONE_NS = 10000;
  localparam logic [7:0] RST_LOW_CYC =
    8'((T_RST_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RST_DONE_CYC = 8'(T_RST_DONE_NS / CLK_NS);

  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_CFG    = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA  = 8'h14;

  // field positions and reset values
  localparam int CFG_WORD_BIT   = 0;
  localparam int CFG_TOP_BIT    = 1;
  localparam int CFG_UNPROT_BIT = 2;
  localparam int CFG_MASK_LSB   = 3;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_ERR_BIT     = 2;
  localparam int ST_REFUSE_BIT  = 3;
  localparam int ST_RB_BIT      = 4;
  localparam int ST_BLK_LSB     = 8;
  localparam logic [31:0] CFG_RESET = 32'h0000_0001;

  // status bits of a polling read
  localparam int POLL_ERR_BIT    = 5;
  localparam int POLL_TOGGLE_BIT = 6;

  // coded cycles and command values (arbitrary defaults)
  localparam logic [15:0] UNLOCK_A1         = 16'h0111;
  localparam logic [15:0] UNLOCK_A2         = 16'h0222;
  localparam logic [7:0]  UNLOCK_D1         = 8'h11;
  localparam logic [7:0]  UNLOCK_D2         = 8'h22;
  localparam logic [7:0]  CMD_READ_ARRAY    = 8'h31;
  localparam logic [7:0]  CMD_AUTO_SELECT   = 8'h32;
  localparam logic [7:0]  CMD_PROGRAM       = 8'h33;
  localparam logic [7:0]  CMD_ERASE_SETUP   = 8'h34;
  localparam logic [7:0]  CMD_BLOCK_CONFIRM = 8'h35;
  localparam logic [7:0]  CMD_CHIP_CONFIRM  = 8'h36;
  localparam logic [7:0]  CMD_SUSPEND       = 8'h37;
  localparam logic [7:0]  CMD_RESUME        = 8'h38;

  // block base word addresses, index 0 boot .. 4 large main
  localparam logic [4:0][15:0] BLK_BASE_TOP =
    {16'h0000, 16'h8000, 16'hd000, 16'hc000, 16'he000};
  localparam logic [4:0][15:0] BLK_BASE_BOT =
    {16'h8000, 16'h4000, 16'h3000, 16'h2000, 16'h0000};
  localparam logic [2:0] BLK_NONE = 3'h7;
  localparam logic [2:0] POLL_IDX = 3'h7;

  typedef enum logic [3:0] {
    OP_READ_ARRAY, OP_AUTO_SELECT, OP_PROGRAM, OP_BLOCK_ERASE,
    OP_CHIP_ERASE, OP_SUSPEND, OP_RESUME, OP_STATUS_READ, OP_HW_RESET
  } fci_op_t;

  typedef struct packed {
    logic        rd;
    logic        am1;
    logic [15:0] adr;
    logic [15:0] dat;
  } fci_cyc_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic drive;
  } fci_strobe_t;

endpackage : fci_pkg

// [rtl/fci_host.sv]
// wishbone-driven host that runs command sequences on the flash pins
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - writes one, two, and for erase four, five, carry the same unlock pattern
// - third write is the set-up command; read cycles follow for reads
// - program: fourth write carries target address and data
// - erase: second unlock in writes four, five, confirm in six
// - address taken at strobe fall, data at strobe rise
// - reset held low at least 500ns; completion within 10us
module fci_host
  import fci_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [15:0] flash_addr_o,
  input  wire logic [15:0] flash_dq_i,
  output logic      [15:0] flash_dq_o,
  output logic      [15:0] flash_dq_oe_n_o,
  output logic             flash_ce_n_o,
  output logic             flash_oe_n_o,
  output logic             flash_we_n_o,
  output logic             flash_word_mode_o,
  output logic             reset_unprotect_n_o,
  output logic             unprotect_hv_o,
  input  wire logic        ready_busy_out_i
);
  import fci_pkg::*;

  typedef enum {ST_IDLE, ST_BUS, ST_RST_LOW, ST_RST_WAIT} fci_state_t;

  fci_state_t  state, next_state;
  fci_op_t     op, next_op;
  fci_cyc_t    item, next_item;
  fci_strobe_t str, next_str;
  logic [2:0]  ph, next_ph;
  logic [2:0]  idx, next_idx;
  logic [2:0]  blk, next_blk;
  logic [7:0]  cnt, next_cnt;
  logic        poll_first, next_poll_first;
  logic        prev_tog, next_prev_tog;
  logic        rst_n_q, next_rst_n_q;
  logic        ev_done, ev_err, ev_refuse;
  logic [31:0] cfg, next_cfg;
  logic [16:0] adr_r, next_adr_r;
  logic [15:0] wdat, next_wdat;
  logic [15:0] rdat, next_rdat;
  logic        done, next_done;
  logic        err, next_err;
  logic        refused, next_refused;
  logic        ack, next_ack;
  logic [31:0] dat_q, next_dat_q;
  logic        wr_acc, start;
  logic [4:0]  mask;
  logic        word_mode, top_boot;

  // lowest block index set in the mask at or above a given index
  function automatic logic [2:0] first_set(input logic [4:0] m,
                                           input logic [2:0] from);
    logic [2:0] r;
    r = BLK_NONE;
    for (int i = 4; i >= 0; i--)
    begin
      if (m[i] && 3'(i) >= from)
        r = 3'(i);
    end
    return r;
  endfunction : first_set

  // upper-address decode of the block that an address falls in
  function automatic logic [2:0] blk_decode(input logic [15:0] a,
                                            input logic top);
    logic [2:0] r;
    r = 3'h0;
    if (top)
    begin
      if (!a[15])                 r = 3'h4;
      else if (!a[14])            r = 3'h3;
      else if (a[13])             r = 3'h0;
      else                        r = a[12] ? 3'h2 : 3'h1;
    end
    else
    begin
      if (a[15])                  r = 3'h4;
      else if (a[14])             r = 3'h3;
      else if (!a[13])            r = 3'h0;
      else                        r = a[12] ? 3'h2 : 3'h1;
    end
    return r;
  endfunction : blk_decode

  // bus cycle that step idx of an operation places on the pins
  function automatic fci_cyc_t seq_item(input fci_op_t o,
                                        input logic [2:0] i,
                                        input logic [15:0] base,
                                        input logic [16:0] a,
                                        input logic [15:0] d);
    fci_cyc_t c;
    logic [7:0] cmd;
    c = '{rd: 1'b0, am1: 1'b0, adr: UNLOCK_A1, dat: {8'h00, UNLOCK_D1}};
    case (o)
      OP_READ_ARRAY:  cmd = CMD_READ_ARRAY;
      OP_AUTO_SELECT: cmd = CMD_AUTO_SELECT;
      OP_PROGRAM:     cmd = CMD_PROGRAM;
      OP_SUSPEND:     cmd = CMD_SUSPEND;
      OP_RESUME:      cmd = CMD_RESUME;
      default:        cmd = CMD_ERASE_SETUP;
    endcase
    // coded cycles one, two, four, five
    if (i == 3'h1 || i == 3'h4)
      c = '{rd: 1'b0, am1: 1'b0, adr: UNLOCK_A2, dat: {8'h00, UNLOCK_D2}};
    // set-up command in the third write
    if (i == 3'h2)
      c.dat = {8'h00, cmd};
    if (i == 3'h3 && o == OP_PROGRAM)
      c = '{rd: 1'b0, am1: a[16], adr: a[15:0], dat: d};
    if (i == 3'h3 && (o == OP_READ_ARRAY || o == OP_AUTO_SELECT))
      c = '{rd: 1'b1, am1: a[16], adr: a[15:0], dat: 16'h0000};
    if (i == 3'h5)
      c = (o == OP_BLOCK_ERASE)
        ? '{rd: 1'b0, am1: 1'b0, adr: base, dat: {8'h00, CMD_BLOCK_CONFIRM}}
        : '{rd: 1'b0, am1: 1'b0, adr: UNLOCK_A1,
            dat: {8'h00, CMD_CHIP_CONFIRM}};
    if (i == POLL_IDX || o == OP_STATUS_READ)
      c = '{rd: 1'b1, am1: a[16],
            adr: (o == OP_BLOCK_ERASE) ? base : a[15:0], dat: 16'h0000};
    return c;
  endfunction : seq_item

  // address steady before strobes fall, data until they rise
  function automatic fci_strobe_t strobe_for(input fci_state_t s,
                                             input logic [2:0] p,
                                             input logic rd);
    fci_strobe_t r;
    r = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, drive: 1'b0};
    if (s == ST_BUS)
    begin
      r.ce_n  = (p == 3'h4);
      r.drive = !rd;
      r.we_n  = rd || !(p == 3'h1 || p == 3'h2);
      r.oe_n  = !rd || !(p == 3'h1 || p == 3'h2);
    end
    return r;
  endfunction : strobe_for

  assign mask      = cfg[CFG_MASK_LSB +: 5];
  assign word_mode = cfg[CFG_WORD_BIT];
  assign top_boot  = cfg[CFG_TOP_BIT];
  assign wr_acc    = wb_cyc_i && wb_stb_i && wb_we_i && ack;
  assign start     = wr_acc && wb_adr_i[7:0] == REG_CTRL && wb_sel_i[0];

  // sequence engine
  always_comb
  begin
    next_state      = state;
    next_op         = op;
    next_ph         = ph;
    next_idx        = idx;
    next_blk        = blk;
    next_cnt        = cnt;
    next_poll_first = poll_first;
    next_prev_tog   = prev_tog;
    next_rst_n_q    = 1'b1;
    next_rdat       = rdat;
    ev_done         = 1'b0;
    ev_err          = 1'b0;
    ev_refuse       = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (start)
        begin
          next_op  = fci_op_t'(wb_dat_i[3:0]);
          next_ph  = 3'h0;
          next_blk = first_set(mask, 3'h0);
          next_idx = (next_op == OP_STATUS_READ) ? POLL_IDX : 3'h0;
          next_poll_first = 1'b1;
          // no program or erase while the device is busy
          if (wb_dat_i[3:0] > 4'(OP_HW_RESET)
              || (!ready_busy_out_i && (next_op == OP_PROGRAM
                  || next_op == OP_BLOCK_ERASE
                  || next_op == OP_CHIP_ERASE))
              || (next_op == OP_BLOCK_ERASE && mask == 5'h00))
            ev_refuse = 1'b1;
          else if (next_op == OP_HW_RESET)
          begin
            next_state   = ST_RST_LOW;
            next_cnt     = 8'h00;
            next_rst_n_q = 1'b0;
          end
          else
            next_state = ST_BUS;
        end
      end
      ST_BUS:
      begin
        next_ph = ph + 3'h1;
        if (ph == 3'h2 && item.rd)
          next_rdat = flash_dq_i;
        if (ph == 3'h4)
        begin
          next_ph = 3'h0;
          if (idx == POLL_IDX)
          begin
            // toggle stop on bit 6 ends polling
            next_prev_tog   = rdat[POLL_TOGGLE_BIT];
            next_poll_first = 1'b0;
            if (op == OP_STATUS_READ)
            begin
              next_state = ST_IDLE;
              ev_done    = 1'b1;
            end
            else if (!poll_first && rdat[POLL_TOGGLE_BIT] == prev_tog
                     && ready_busy_out_i)
            begin
              next_state = ST_IDLE;
              ev_done    = 1'b1;
            end
            // data after completion may hold bit 5 set: only fail while busy
            else if (!poll_first && rdat[POLL_ERR_BIT]
                     && rdat[POLL_TOGGLE_BIT] != prev_tog
                     && !ready_busy_out_i)
            begin
              next_state = ST_IDLE;
              ev_err     = 1'b1;
            end
          end
          // program runs after the fourth write
          else if (op == OP_PROGRAM && idx == 3'h3)
            next_idx = POLL_IDX;
          else if (op == OP_BLOCK_ERASE && idx == 3'h5)
          begin
            next_blk = first_set(mask, blk + 3'h1);
            if (next_blk == BLK_NONE)
            begin
              next_blk = blk;
              next_idx = POLL_IDX;
            end
          end
          // erase runs after the sixth write
          else if (op == OP_CHIP_ERASE && idx == 3'h5)
            next_idx = POLL_IDX;
          // suspend and resume are three writes
          else if ((op == OP_SUSPEND || op == OP_RESUME) && idx == 3'h2)
          begin
            next_state = ST_IDLE;
            ev_done    = 1'b1;
          end
          else if (idx == 3'h3 && item.rd)
          begin
            next_state = ST_IDLE;
            ev_done    = 1'b1;
          end
          else
            next_idx = idx + 3'h1;
        end
      end
      ST_RST_LOW:
      begin
        // reset pin low for the least pulse width
        next_cnt     = cnt + 8'h01;
        next_rst_n_q = (cnt == RST_LOW_CYC - 8'h01);
        if (next_rst_n_q)
        begin
          next_state = ST_RST_WAIT;
          next_cnt   = 8'h00;
        end
      end
      ST_RST_WAIT:
      begin
        // wait for ready/busy, give up after the longest time
        next_cnt = cnt + 8'h01;
        if (cnt != 8'h00 && ready_busy_out_i)
        begin
          next_state = ST_IDLE;
          ev_done    = 1'b1;
        end
        else if (cnt == RST_DONE_CYC)
        begin
          next_state = ST_IDLE;
          ev_err     = 1'b1;
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
    next_item = seq_item(next_op, next_idx,
                         top_boot ? BLK_BASE_TOP[next_blk]
                                  : BLK_BASE_BOT[next_blk],
                         adr_r, wdat);
    next_str = strobe_for(next_state, next_ph, next_item.rd);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state      <= ST_IDLE;
      op         <= OP_READ_ARRAY;
      ph         <= 3'h0;
      idx        <= 3'h0;
      blk        <= 3'h0;
      cnt        <= 8'h00;
      poll_first <= 1'b1;
      prev_tog   <= 1'b0;
      rst_n_q    <= 1'b1;
      rdat       <= 16'h0000;
      item       <= '0;
      str        <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, drive: 1'b0};
    end
    else
    begin
      state      <= next_state;
      op         <= next_op;
      ph         <= next_ph;
      idx        <= next_idx;
      blk        <= next_blk;
      cnt        <= next_cnt;
      poll_first <= next_poll_first;
      prev_tog   <= next_prev_tog;
      rst_n_q    <= next_rst_n_q;
      rdat       <= next_rdat;
      item       <= next_item;
      str        <= next_str;
    end
  end

  // pins; strobes stay registered so they never glitch
  assign flash_ce_n_o        = str.ce_n;
  assign flash_oe_n_o        = str.oe_n;
  assign flash_we_n_o        = str.we_n;
  assign flash_addr_o        = item.adr;
  assign flash_word_mode_o   = word_mode;
  assign reset_unprotect_n_o = rst_n_q;
  // request the identification_high_voltage level on the reset pin
  assign unprotect_hv_o      = cfg[CFG_UNPROT_BIT] && rst_n_q;
  // byte mode: top line carries the low address bit
  assign flash_dq_o = word_mode ? item.dat : {item.am1, 7'h00, item.dat[7:0]};
  // word mode drives all sixteen lines on writes
  assign flash_dq_oe_n_o = {!(str.drive && word_mode) && word_mode,
                            {7{!(str.drive && word_mode)}},
                            {8{!str.drive}}};

  // register file
  always_comb
  begin
    next_ack     = wb_cyc_i && wb_stb_i && !ack;
    next_cfg     = cfg;
    next_adr_r   = adr_r;
    next_wdat    = wdat;
    next_dat_q   = dat_q;
    next_done    = done || ev_done;
    next_err     = err || ev_err;
    next_refused = refused || ev_refuse;
    if (wr_acc && wb_sel_i[0])
    begin
      case (wb_adr_i[7:0])
        REG_ADDR:  next_adr_r = wb_dat_i[16:0];
        REG_WDATA: next_wdat  = wb_dat_i[15:0];
        REG_CFG:   next_cfg   = {24'h0, wb_dat_i[7:0]};
        REG_STATUS:
        begin
          // write one clears, a same-cycle event still wins
          next_done    = (done && !wb_dat_i[ST_DONE_BIT]) || ev_done;
          next_err     = (err && !wb_dat_i[ST_ERR_BIT]) || ev_err;
          next_refused = (refused && !wb_dat_i[ST_REFUSE_BIT]) || ev_refuse;
        end
        default: next_cfg = cfg;
      endcase
    end
    if (next_ack)
    begin
      case (wb_adr_i[7:0])
        REG_CTRL:  next_dat_q = {28'h0, op};
        REG_ADDR:  next_dat_q = {15'h0, adr_r};
        REG_WDATA: next_dat_q = {16'h0, wdat};
        REG_CFG:   next_dat_q = cfg;
        // progress and ready/busy visible at any time
        REG_STATUS: next_dat_q = {21'h0, blk_decode(adr_r[15:0], top_boot),
                                  3'h0, ready_busy_out_i, refused, err, done,
                                  state != ST_IDLE};
        REG_RDATA: next_dat_q = {16'h0, rdat};
        default:   next_dat_q = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack     <= 1'b0;
      cfg     <= CFG_RESET;
      adr_r   <= 17'h0;
      wdat    <= 16'h0;
      dat_q   <= 32'h0;
      done    <= 1'b0;
      err     <= 1'b0;
      refused <= 1'b0;
    end
    else
    begin
      ack     <= next_ack;
      cfg     <= next_cfg;
      adr_r   <= next_adr_r;
      wdat    <= next_wdat;
      dat_q   <= next_dat_q;
      done    <= next_done;
      err     <= next_err;
      refused <= next_refused;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = dat_q;

  // count of completed write strobes, for the checks below
  logic [3:0] wr_cnt;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || start)
      wr_cnt <= 4'h0;
    else if (!str.we_n && next_str.we_n)
      wr_cnt <= wr_cnt + 4'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence write_rise;
    $rose(flash_we_n_o);
  endsequence
  sequence poll_entry;
    state == ST_BUS && idx == POLL_IDX && $past(idx) != POLL_IDX;
  endsequence

  prog_four_a: assert property (
    poll_entry and op == OP_PROGRAM |-> wr_cnt == 4'h4)
    else $error("program polled without four writes");
  chip_six_a: assert property (
    poll_entry and op == OP_CHIP_ERASE |-> wr_cnt == 4'h6)
    else $error("chip erase polled without six writes");
  unlock_first_a: assert property (
    write_rise and wr_cnt == 4'h1 and op != OP_STATUS_READ
    |-> flash_addr_o == UNLOCK_A1 && flash_dq_o[7:0] == UNLOCK_D1)
    else $error("first write is not the unlock pattern");
  addr_hold_a: assert property (
    !flash_we_n_o |=> $stable(flash_addr_o) && $stable(flash_dq_o)
                      && !flash_ce_n_o)
    else $error("address or data moved under write strobe");
  busy_refuse_a: assert property (
    start && state == ST_IDLE && !ready_busy_out_i
    && wb_dat_i[3:0] == 4'(OP_PROGRAM) |=> refused && state == ST_IDLE)
    else $error("program accepted while busy");
  rst_pulse_a: assert property (
    $fell(reset_unprotect_n_o) |-> !reset_unprotect_n_o [*5])
    else $error("reset pulse too short");
  byte_lane_a: assert property (
    !flash_word_mode_o |-> flash_dq_oe_n_o[14:8] == 7'h7f
                           && !flash_dq_oe_n_o[15])
    else $error("byte mode lane drive wrong");
  word_drive_a: assert property (
    flash_word_mode_o && !flash_we_n_o |-> flash_dq_oe_n_o == 16'h0000)
    else $error("word write not driving all lines");
  strobe_excl_a: assert property (
    !(flash_we_n_o == 1'b0 && flash_oe_n_o == 1'b0))
    else $error("write and output strobes both low");

endmodule : fci_host

`default_nettype wire

// [bench/fci_flash_model.sv]
// behavioural flash device facing the command host
`timescale 1ns/1ns
`default_nettype none
module fci_flash_model
  import fci_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        rst_n_i,
  input  wire logic        hold_i,
  output logic      [15:0] dq_o,
  output logic             rb_o
);
  localparam int BUSY_CYC = 20;
  logic [15:0] a_lat, last_a, last_d, rd_val;
  logic [15:0] last_out = 16'h0;
  logic [7:0]  cmd = 8'h0;
  logic        tog = 1'b0;
  logic        odd;
  int          k = 0, n_wr = 0, n_bad = 0, busy = 0, rst_low = 0;
  int          rst_max = 0;
  wire         wr_n = ce_n_i | we_n_i;
  // address at the later strobe fall
  always @(negedge wr_n)
    a_lat = addr_i;
  // data at first rise, writes only
  always @(posedge wr_n)
    if ($time > 100)
    begin
      n_wr++;
      k++;
      odd = (k == 1 || k == 4);
      last_a = a_lat;
      last_d = dq_i;
      if (k == 3)
        cmd = dq_i[7:0];
      else if (k == 6 || k == 4 && cmd == CMD_PROGRAM)
        busy = BUSY_CYC;
      else if (a_lat != (odd ? UNLOCK_A1 : UNLOCK_A2) ||
               dq_i[7:0] != (odd ? UNLOCK_D1 : UNLOCK_D2))
      begin
        n_bad++;
        k = 0;
      end
      if (k == 6 || k == 4 && cmd == CMD_PROGRAM ||
          k == 3 && cmd != CMD_PROGRAM && cmd != CMD_ERASE_SETUP)
        k = 0;
    end
  // reset low drops the sequence; low time is measured
  always @(posedge clk_i)
  begin
    if (busy > 0)
      busy <= busy - 1; // host must see the pre-edge level
    rst_low = (rst_n_i === 1'b0) ? rst_low + 1 : 0;
    if (rst_low > 0)
      k = 0;
    if (rst_low > rst_max)
      rst_max = rst_low;
    if (!ce_n_i && !oe_n_i)
      last_out <= rd_val;
  end
  // ready/busy low while the algorithm runs
  assign rb_o = !(busy > 0 || hold_i);
  // polling on bit 7, toggles on bits 6 and 2
  always @(negedge oe_n_i)
    if (busy > 0)
      tog = ~tog;
  // array data is a fixed function of the address
  assign rd_val = busy > 0 ? {8'h00, ~last_d[7], tog, 3'h0, tog, 2'h0}
                           : addr_i ^ 16'h5a5a;
  // released bus inverts, so a stale copy never passes
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd_val : ~last_out;
endmodule : fci_flash_model
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the flash command host
`timescale 1ns/1ns
`default_nettype none
module tb;
  import fci_pkg::*;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, hold = 0;
  logic [31:0] adr = 0, wdat = 0, rdat, q;
  logic        ack, ce_n, oe_n, we_n, wmode, rp_n, hv, rb;
  logic [15:0] fa, fdo, foe_n, mdq, bus;
  int          err_total = 0, check_count = 0, ticks = 0, n0;
  int          exp_n[7] = '{3, 3, 4, 6, 6, 3, 3};
  logic [15:0] ba[10] = '{16'hf123, 16'hc800, 16'hd001, 16'ha000,
    16'h7fff, 16'h1fff, 16'h2abc, 16'h3000, 16'h7000, 16'hffff};
  assign bus = (foe_n & mdq) | (~foe_n & fdo);
  always #50 clk = ~clk;
  fci_host dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .flash_addr_o(fa), .flash_dq_i(bus),
    .flash_dq_o(fdo), .flash_dq_oe_n_o(foe_n), .flash_ce_n_o(ce_n),
    .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_word_mode_o(wmode),
    .reset_unprotect_n_o(rp_n), .unprotect_hv_o(hv), .ready_busy_out_i(rb));
  fci_flash_model m (.clk_i(clk), .addr_i(fa), .dq_i(bus), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .rst_n_i(rp_n), .hold_i(hold),
    .dq_o(mdq), .rb_o(rb));
  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {24'h0, a};
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    q = rdat;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask : wb
  task automatic run(input logic [3:0] op);
    wb(1, REG_STATUS, 32'h7);
    wb(1, REG_CTRL, {28'h0, op});
    repeat (300)
    begin
      wb(0, REG_STATUS, 0);
      if (q[ST_BUSY_BIT] === 1'b0)
        break;
    end
  endtask : run
  task automatic end_sim;
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 60000)
    begin
      err_total++;
      end_sim();
    end
  end
  // byte mode: top line carries the low address, middle lines released
  always @(negedge clk)
    if (!rst && !wmode && !oe_n)
    begin
      chk("oe15", 0, foe_n[15]);
      chk("oe14_8", 7'h7f, foe_n[14:8]);
      chk("a_m1", 1, fdo[15]);
    end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk("ce_n", 1, ce_n);
    wb(0, REG_CFG, 0);
    chk("cfg", CFG_RESET, q);
    chk("wmode", 1, wmode);
    wb(0, 8'h20, 0);
    chk("unmapped", 0, q);
    wb(1, REG_ADDR, 32'h1234);
    wb(1, REG_WDATA, 32'hc3a5);
    for (int i = 0; i < 7; i++)
    begin
      // block erase needs one block in the mask, the boot block here
      wb(1, REG_CFG, i == 3 ? 32'h9 : 32'h1);
      n0 = m.n_wr;
      run(4'(i));
      chk("writes", exp_n[i], m.n_wr - n0);
      chk("done", 1, q[ST_DONE_BIT]);
      chk("err", 0, q[ST_ERR_BIT]);
      if (i == 2)
        chk("prog", 32'h1234c3a5, {m.last_a, m.last_d});
      if (i == 3)
        chk("blk_base", BLK_BASE_BOT[0], m.last_a);
    end
    wb(0, REG_RDATA, 0);
    chk("rdata", 32'h486e, q);
    chk("bad", 0, m.n_bad);
    wb(1, REG_CFG, 32'h1);
    // unknown op, empty block mask, start while busy
    for (int j = 0; j < 3; j++)
    begin
      hold <= (j == 2);
      wb(1, REG_STATUS, 32'h8);
      n0 = m.n_wr;
      wb(1, REG_CTRL, j == 0 ? 32'h9 : j == 1 ? 32'h3 : 32'h2);
      wb(0, REG_STATUS, 0);
      chk("refused", 1, q[ST_REFUSE_BIT]);
      chk("rb_bit", j != 2, q[ST_RB_BIT]);
      chk("nowrite", n0, m.n_wr);
    end
    hold <= 0;
    for (int b = 0; b < 10; b++)
    begin
      wb(1, REG_CFG, b < 5 ? 32'h3 : 32'h1);
      wb(1, REG_ADDR, {16'h0, ba[b]});
      wb(0, REG_STATUS, 0);
      chk("block", b % 5, q[10:8]);
    end
    wb(1, REG_CFG, 32'h5);
    @(posedge clk);
    chk("hv", 1, hv);
    run(4'h8);
    chk("rst_low", 1, m.rst_max >= RST_LOW_CYC);
    chk("rp_n", 1, rp_n);
    wb(1, REG_ADDR, 32'h10055);
    wb(1, REG_CFG, 32'h0);
    run(4'h0);
    chk("wmode", 0, wmode);
    end_sim();
  end
endmodule : tb
`default_nettype wire
